/* File: common/code_store_pkg.sv */
// shared constants and types for the code store protection block
package code_store_pkg;
   localparam int ADDR_W = 16;          // 64 kbytes of code store
   localparam int DATA_W = 8;
   localparam int KEY_DEPTH = 64;        // scramble table 00H..3FH
   localparam int KEY_ADDR_W = 6;
   localparam logic [15:0] SIG_MAKER_ADDR = 16'h0030;
   localparam logic [15:0] SIG_PART_ADDR = 16'h0031;
   // arbitrary identity values
   localparam logic [7:0] SIG_MAKER_VAL = 8'hA5;
   localparam logic [7:0] SIG_PART_VAL = 8'h5A;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [2:0] LOCK_RESET = 3'h0;
   // programmer command modes decoded from the mode pins
   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_READ_SIG,
      MODE_PROG_CODE,
      MODE_VERIFY,
      MODE_PROG_KEY,
      MODE_PROG_LOCK1,
      MODE_PROG_LOCK2,
      MODE_PROG_LOCK3
   } prog_mode_t;
   // protection levels 1..4
   typedef enum logic [1:0] {
      LEVEL_1,
      LEVEL_2,
      LEVEL_3,
      LEVEL_4
   } prot_level_t;
endpackage

/* File: common/key_if.sv */
// carrier between the main block and the scramble table store
`timescale 1ns/1ps
interface key_if;
   logic wr;
   logic clear;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic [5:0] rd_addr;
   logic [7:0] rd_data;
   logic programmed;
   modport host (output wr, clear, wr_addr, wr_data, rd_addr,
      input rd_data, programmed);
   modport store (input wr, clear, wr_addr, wr_data, rd_addr,
      output rd_data, programmed);
endinterface

/* File: logic/key_table.sv */
// scramble table store, write only from outside, read only inside
`timescale 1ns/1ps
module key_table #(
   parameter int DEPTH = code_store_pkg::KEY_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_in,
   key_if.store kt
);
   logic [7:0] mem [DEPTH];
   logic [7:0] next_mem [DEPTH];
   logic programmed;
   logic next_programmed;

   // next table contents: clear on erase, else write a byte
   always_comb begin
      next_mem = mem;
      next_programmed = programmed;
      if (kt.clear) begin
         for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = code_store_pkg::ERASED_BYTE;
         end
         next_programmed = 1'b0;
      end else if (kt.wr) begin
         next_mem[kt.wr_addr] = kt.wr_data;
         next_programmed = 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= code_store_pkg::ERASED_BYTE;
         end
         programmed <= 1'b0;
      end else begin
         mem <= next_mem;
         programmed <= next_programmed;
      end
   end

   assign kt.rd_data = mem[kt.rd_addr];
   assign kt.programmed = programmed;
endmodule

/* File: logic/code_store_lock_and_encrypt.sv */
// code store with signature, scramble table and lock bit protection
`timescale 1ns/1ps
module code_store_lock_and_encrypt #(
   parameter int ADDR_W = code_store_pkg::ADDR_W
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // programmer side
   input wire logic [2:0] mode_in,
   input wire logic prog_strobe_in,
   input wire logic erase_in,
   input wire logic [ADDR_W-1:0] prog_addr_in,
   input wire logic [7:0] prog_data_in,
   output logic [7:0] port0_data_out,
   output logic port0_oe_n_out,
   // running core side
   input wire logic core_read_in,
   input wire logic [ADDR_W-1:0] core_addr_in,
   input wire logic core_from_external_in,
   input wire logic external_access_pin_in,
   output logic [7:0] core_data_out,
   output logic core_blocked_out,
   output logic run_external_out,
   output logic prog_refused_out
);
   localparam int DEPTH = 1 << ADDR_W;
   // signature locations, declared ahead of the decode that reads them
   localparam logic [15:0] SIG_MAKER = code_store_pkg::SIG_MAKER_ADDR;
   localparam logic [15:0] SIG_PART = code_store_pkg::SIG_PART_ADDR;
   code_store_pkg::prog_mode_t mode;
   assign mode = code_store_pkg::prog_mode_t'(mode_in);

   key_if kt ();
   key_table #(.DEPTH(code_store_pkg::KEY_DEPTH)) u_key (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .kt(kt)
   );

   // code store array
   logic [7:0] code_mem [DEPTH];
   logic [2:0] lock;
   logic [2:0] next_lock;
   logic strobe_q;
   logic next_strobe_q;
   logic ea_latched;
   logic next_ea_latched;
   logic ea_caught;
   logic next_ea_caught;
   logic [7:0] port0_data;
   logic [7:0] next_port0_data;
   logic port0_oe_n;
   logic next_port0_oe_n;
   logic [7:0] core_data;
   logic [7:0] next_core_data;
   logic core_blocked;
   logic next_core_blocked;
   logic run_external;
   logic next_run_external;
   logic prog_refused;
   logic next_prog_refused;
   code_store_pkg::prot_level_t level;
   logic pulse;
   logic lvl2;
   logic lvl3;
   logic lvl4;
   logic ea_eff;
   logic code_wr;
   logic key_wr;

   // level decode from lock bits, highest full set wins
   always_comb begin
      if (lock[0] && lock[1] && lock[2]) begin
         level = code_store_pkg::LEVEL_4;
      end else if (lock[0] && lock[1]) begin
         level = code_store_pkg::LEVEL_3;
      end else if (lock[0]) begin
         level = code_store_pkg::LEVEL_2;
      end else begin
         level = code_store_pkg::LEVEL_1; // no limits
      end
   end
   assign lvl2 = (level != code_store_pkg::LEVEL_1);
   assign lvl3 = (level == code_store_pkg::LEVEL_3) ||
      (level == code_store_pkg::LEVEL_4);
   assign lvl4 = (level == code_store_pkg::LEVEL_4);
   // one write per rising strobe edge; pulse count is the programmer's
   assign pulse = prog_strobe_in && !strobe_q;
   // write strobes honoured only below level two
   assign code_wr = pulse && !lvl2 &&
      (mode == code_store_pkg::MODE_PROG_CODE);
   assign key_wr = pulse && !lvl2 &&
      (mode == code_store_pkg::MODE_PROG_KEY);
   // access pin seen live below level two, latched after reset release from level two
   assign ea_eff = lvl2 ? ea_latched : external_access_pin_in;

   // scramble table write and erase strobes
   always_comb begin
      kt.wr = key_wr;
      kt.clear = erase_in;
      kt.wr_addr = prog_addr_in[5:0];
      kt.wr_data = prog_data_in;
      kt.rd_addr = prog_addr_in[5:0];
   end

   // access pin latch, taken once after reset release
   always_comb begin
      next_ea_latched = ea_latched;
      next_ea_caught = ea_caught;
      // catch access pin on first clock after reset release
      if (!ea_caught) begin
         next_ea_latched = external_access_pin_in;
         next_ea_caught = 1'b1;
      end
   end

   // lock bits, strobe history and refusal flag
   always_comb begin
      next_lock = lock;
      next_strobe_q = prog_strobe_in;
      next_prog_refused = prog_refused;
      if (erase_in) begin
         next_lock = code_store_pkg::LOCK_RESET;
         next_prog_refused = 1'b0;
      end else if (pulse) begin
         case (mode)
            code_store_pkg::MODE_PROG_CODE,
            code_store_pkg::MODE_PROG_KEY: begin
               next_prog_refused = lvl2;
            end
            code_store_pkg::MODE_PROG_LOCK1: begin
               next_lock[0] = 1'b1;
            end
            code_store_pkg::MODE_PROG_LOCK2: begin
               next_lock[1] = 1'b1;
            end
            code_store_pkg::MODE_PROG_LOCK3: begin
               next_lock[2] = 1'b1;
            end
            default: begin
               next_prog_refused = prog_refused;
            end
         endcase
      end
   end

   // verify and signature bytes on port 0
   always_comb begin
      next_port0_data = 8'h00;
      next_port0_oe_n = 1'b1;
      case (mode)
         code_store_pkg::MODE_READ_SIG: begin
            next_port0_oe_n = 1'b0;
            if (prog_addr_in == SIG_MAKER[ADDR_W-1:0]) begin
               next_port0_data = code_store_pkg::SIG_MAKER_VAL;
            end else if (prog_addr_in == SIG_PART[ADDR_W-1:0]) begin
               next_port0_data = code_store_pkg::SIG_PART_VAL;
            end
         end
         code_store_pkg::MODE_VERIFY: begin
            // verify off at level three and four
            if (!lvl3) begin
               next_port0_oe_n = 1'b0;
               // scrambled data once the table is written, raw code before that; an erased FFH byte shows the table byte itself
               if (kt.programmed) begin
                  next_port0_data = ~(code_mem[prog_addr_in] ^ kt.rd_data);
               end else begin
                  next_port0_data = code_mem[prog_addr_in];
               end
            end
         end
         default: begin
            next_port0_oe_n = 1'b1;
         end
      endcase
   end

   // core table reads and execution source
   always_comb begin
      next_core_data = 8'h00;
      next_core_blocked = 1'b0;
      // low pin forces external run except at level four
      next_run_external = !ea_eff && !lvl4;
      // table reads from external code blocked from level two
      if (core_read_in) begin
         if (lvl2 && core_from_external_in) begin
            next_core_blocked = 1'b1;
         end else begin
            next_core_data = code_mem[core_addr_in];
         end
      end
   end

   // code array writes and erase; refused once level two set
   always_ff @(posedge clk_in) begin
      if (erase_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            code_mem[i] <= code_store_pkg::ERASED_BYTE;
         end
      end else if (code_wr) begin
         code_mem[prog_addr_in] <= prog_data_in;
      end
   end

   // lock bits have no output path of their own
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock <= code_store_pkg::LOCK_RESET;
         strobe_q <= 1'b0;
         prog_refused <= 1'b0;
      end else begin
         lock <= next_lock;
         strobe_q <= next_strobe_q;
         prog_refused <= next_prog_refused;
      end
   end

   // access pin latch; reads high until the pin is caught
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ea_latched <= 1'b1;
         ea_caught <= 1'b0;
      end else begin
         ea_latched <= next_ea_latched;
         ea_caught <= next_ea_caught;
      end
   end

   // port 0 output registers, released while in reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         port0_data <= 8'h00;
         port0_oe_n <= 1'b1;
      end else begin
         port0_data <= next_port0_data;
         port0_oe_n <= next_port0_oe_n;
      end
   end

   // core side output registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         core_data <= 8'h00;
         core_blocked <= 1'b0;
         run_external <= 1'b0;
      end else begin
         core_data <= next_core_data;
         core_blocked <= next_core_blocked;
         run_external <= next_run_external;
      end
   end

   assign port0_data_out = port0_data;
   assign port0_oe_n_out = port0_oe_n;
   assign core_data_out = core_data;
   assign core_blocked_out = core_blocked;
   assign run_external_out = run_external;
   assign prog_refused_out = prog_refused;
endmodule

/* File: dv/code_store_props.sv */
// port checks for the code store protection block
`timescale 1ns/1ps
module code_store_props #(
   parameter int ADDR_W = code_store_pkg::ADDR_W
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [2:0] mode_in,
   input wire logic prog_strobe_in,
   input wire logic erase_in,
   input wire logic [ADDR_W-1:0] prog_addr_in,
   input wire logic [7:0] port0_data_out,
   input wire logic port0_oe_n_out,
   input wire logic core_read_in,
   input wire logic core_from_external_in,
   input wire logic [7:0] core_data_out,
   input wire logic core_blocked_out,
   input wire logic prog_refused_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // signature bytes and port 0 drive
   a_sig_maker: assert property (mode_in == 3'h1 &&
      prog_addr_in == 16'h0030 |=> !port0_oe_n_out &&
      port0_data_out == code_store_pkg::SIG_MAKER_VAL) else $error("maker");
   a_sig_part: assert property (mode_in == 3'h1 &&
      prog_addr_in == 16'h0031 |=> !port0_oe_n_out &&
      port0_data_out == code_store_pkg::SIG_PART_VAL) else $error("part");
   a_port0_quiet: assert property (mode_in != 3'h1 &&
      mode_in != 3'h3 |=> port0_oe_n_out && port0_data_out == 8'h00)
      else $error("port 0 driven");
   // core read path
   a_core_idle: assert property (!core_read_in |=>
      !core_blocked_out && core_data_out == 8'h00) else $error("idle read");
   a_internal_ok: assert property (core_read_in &&
      !core_from_external_in |=> !core_blocked_out) else $error("blocked");
   a_blocked_empty: assert property (core_blocked_out |->
      core_data_out == 8'h00) else $error("blocked data leaks");
   // refusal flag
   a_refuse_cause: assert property ($rose(prog_refused_out) |->
      $past(prog_strobe_in) && ($past(mode_in) == 3'h2 ||
      $past(mode_in) == 3'h4)) else $error("refusal without pulse");
   a_erase_clears: assert property (erase_in |=>
      !prog_refused_out) else $error("refusal kept by erase");
   c_blocked: cover property ($rose(core_blocked_out));
   c_verify: cover property (mode_in == 3'h3 ##1 !port0_oe_n_out);
   c_refused: cover property ($rose(prog_refused_out));
endmodule

bind code_store_lock_and_encrypt code_store_props #(.ADDR_W(ADDR_W)) cp_u (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .mode_in(mode_in),
   .prog_strobe_in(prog_strobe_in),
   .erase_in(erase_in),
   .prog_addr_in(prog_addr_in),
   .port0_data_out(port0_data_out),
   .port0_oe_n_out(port0_oe_n_out),
   .core_read_in(core_read_in),
   .core_from_external_in(core_from_external_in),
   .core_data_out(core_data_out),
   .core_blocked_out(core_blocked_out),
   .prog_refused_out(prog_refused_out)
);

/* File: dv/prog_model.sv */
// programmer model driving mode, strobe, erase, address and data
`timescale 1ns/1ps
module prog_model (
   input wire logic clk_in,
   output logic [2:0] mode_out,
   output logic strobe_out,
   output logic erase_out,
   output logic [15:0] addr_out,
   output logic [7:0] data_out
);
   initial {mode_out, strobe_out, erase_out, addr_out, data_out} = '0;
   // select a read mode; released data lines toggle
   task automatic setup(input logic [2:0] m, input logic [15:0] a);
      @(negedge clk_in);
      mode_out <= m;
      addr_out <= a;
      data_out <= ~data_out;
   endtask
   // five pulses per location, active then idle
   task automatic burn(input logic [2:0] m, input logic [15:0] a,
      input logic [7:0] d);
      @(negedge clk_in);
      mode_out <= m;
      addr_out <= a;
      data_out <= d;
      repeat (5) begin
         @(negedge clk_in) strobe_out <= 1'b1;
         repeat (3) @(negedge clk_in);
         strobe_out <= 1'b0;
         @(negedge clk_in);
      end
      mode_out <= 3'h0;
      addr_out <= ~a;
   endtask
   // one cycle of erase
   task automatic wipe();
      @(negedge clk_in);
      erase_out <= 1'b1;
      @(negedge clk_in);
      erase_out <= 1'b0;
   endtask
endmodule

/* File: dv/code_store_lock_and_encrypt_tb.sv */
// self-checking bench for the code store protection block
`timescale 1ns/1ps
module code_store_lock_and_encrypt_tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic core_read_in = 1'b0;
   logic core_from_external_in = 1'b0;
   logic external_access_pin_in = 1'b1;
   logic [15:0] core_addr_in = 16'h0000;
   logic [15:0] a, prog_addr_in;
   logic [2:0] mode_in;
   logic prog_strobe_in, erase_in, port0_oe_n_out, core_blocked_out;
   logic run_external_out, prog_refused_out;
   logic [7:0] prog_data_in, port0_data_out, core_data_out;
   int errors = 0;
   int checks = 0;
   int code[int];
   int key[64];
   int locks, keyset, latched, refused;
   // one steady clock for run and programming modes
   always #2.5 clk_in = ~clk_in;
   prog_model pm_u (.clk_in(clk_in), .mode_out(mode_in),
      .strobe_out(prog_strobe_in), .erase_out(erase_in),
      .addr_out(prog_addr_in), .data_out(prog_data_in));
   code_store_lock_and_encrypt dut_u (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .mode_in(mode_in),
      .prog_strobe_in(prog_strobe_in),
      .erase_in(erase_in),
      .prog_addr_in(prog_addr_in),
      .prog_data_in(prog_data_in),
      .port0_data_out(port0_data_out),
      .port0_oe_n_out(port0_oe_n_out),
      .core_read_in(core_read_in),
      .core_addr_in(core_addr_in),
      .core_from_external_in(core_from_external_in),
      .external_access_pin_in(external_access_pin_in),
      .core_data_out(core_data_out),
      .core_blocked_out(core_blocked_out),
      .run_external_out(run_external_out),
      .prog_refused_out(prog_refused_out)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // reference model state
   function automatic int level();
      return locks[0] ? (locks[1] ? (locks[2] ? 4 : 3) : 2) : 1;
   endfunction
   function automatic void clear();
      foreach (key[i]) key[i] = 255;
      {keyset, locks, refused} = '0;
   endfunction
   task automatic reboot(input int n);
      rst_in = 1'b1;
      repeat (n) @(negedge clk_in);
      rst_in = 1'b0;
      latched = external_access_pin_in;
      clear();
   endtask
   task automatic prog(input logic [2:0] m, input logic [15:0] ad,
      input logic [7:0] d);
      pm_u.burn(m, ad, d);
      if (m > 4) locks |= 1 << (m - 5);
      else if (level() > 1) refused = 1;
      else begin
         refused = 0;
         if (m == 2) code[ad] = d;
         else key[ad[5:0]] = d;
         if (m == 4) keyset = 1;
      end
   endtask
   // one read cycle compared on every output
   task automatic look(input logic [2:0] m, input logic [15:0] ad,
      input logic fe);
      int c, lv, oe, p;
      pm_u.setup(m, ad);
      core_read_in <= 1'b1;
      core_addr_in <= ad;
      core_from_external_in <= fe;
      @(negedge clk_in);
      c = code.exists(ad) ? code[ad] : 255;
      lv = level();
      oe = !(m == 1 || (m == 3 && lv < 3));
      p = keyset ? ~(c ^ key[ad[5:0]]) & 255 : c;
      if (m == 1) p = ad[0] ? code_store_pkg::SIG_PART_VAL
         : code_store_pkg::SIG_MAKER_VAL;
      else if (oe) p = 0;
      check(port0_oe_n_out, oe);
      check(port0_data_out, p);
      check(core_blocked_out, fe && lv > 1);
      check(core_data_out, fe && lv > 1 ? 0 : c);
      check(run_external_out, lv == 4 ? 0 : lv > 1 ? !latched
         : !external_access_pin_in);
      check(prog_refused_out, refused);
   endtask
   // hang guard
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   // main sequence
   initial begin
      void'($urandom(32'hd23b));
      reboot(8);
      pm_u.wipe();
      look(3'h0, 16'h0000, 1'b0);
      look(3'h1, 16'h0030, 1'b0);
      look(3'h1, 16'h0031, 1'b1);
      for (int i = 0; i < 4; i++) begin
         a = i == 0 ? 16'hFFFF : 16'($urandom);
         prog(3'h2, a, 8'($urandom));
         look(3'h3, a, 1'b1);
         prog(3'h4, a, 8'($urandom));
         look(3'h3, a, 1'b0);
      end
      external_access_pin_in = 1'b0;
      look(3'h0, a, 1'b0);
      reboot(2);
      @(negedge clk_in);
      external_access_pin_in = 1'b1;
      for (int m = 5; m < 8; m++) begin
         prog(3'(m), 16'h0000, 8'h00);
         prog(3'h4, a, 8'($urandom));
         prog(3'h2, a, 8'($urandom));
         look(3'h3, a, m < 7);
      end
      pm_u.wipe();
      code.delete();
      clear();
      look(3'h3, a, 1'b1);
      wrap_up();
   end
endmodule
